// *** rtl/tms_monitor.sv ***
// Purpose: status, configuration, rate and limit registers of a four channel
//          temperature monitor, with limit compare and alert/critical outputs
// Assumes: an SMBus protocol engine on the same clock presents register accesses;
//          converter results and fault/critical flags arrive on the same clock
// Notes:   read data is registered one cycle after reg_rd
//
// Functional notes
// - busy bit tracks conversion, never raises outputs
// - high bit set on high breach, raises alert
// - low bit set on low breach, raises alert in interrupt mode only
// - fault bit set on diode fault, raises alert in interrupt mode only
// - critical bit drives critical output, not alert
// - high, low and fault summary bits clear when their status is read; therm follows therm_over
// - config at two addresses, resets to 80h
// - mask-all silences alert in interrupt mode
// - bit 5 picks interrupt or comparator mode
// - bit 4 disables correction on channel 1
// - bit 3 disables correction on channels 2, 3
// - bit 2 selects binary or offset range
// - bit 1 inhibits averaging, caps at 1x
// - bit 0 selects paired or single diode
// - four-bit rate code, 1/16 to 64 per second
// - high is strictly greater, low is less-or-equal
// - aliased limit addresses share one storage
// - new limits apply from next conversion
// - results are 11 bits, fraction left-justified
`timescale 1ns/100ps
module tms_monitor
   import tms_pkg::*;
#(
   parameter int unsigned FAST_CYC = FAST_PERIOD_CYC
)
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output      logic [7:0]  reg_rdata,
   output      logic        reg_rvalid,
   input  wire logic        conv_busy,
   input  wire logic        conv_start,
   input  wire logic        conv_done,
   input  wire logic [10:0] int_temp,
   input  wire logic [10:0] ext1_temp,
   input  wire logic [10:0] ext2_temp,
   input  wire logic [10:0] ext3_temp,
   input  wire logic [2:0]  diode_fault,
   input  wire logic [3:0]  therm_over,
   output      logic        warn_output,
   output      logic        crit_output,
   output      logic        conv_request,
   output      logic [3:0]  rate_code,
   output      logic        averaging_inhibit,
   output      logic        chan1_resistance_corr_off,
   output      logic        chan23_resistance_corr_off,
   output      logic        ext_range,
   output      logic        paired_diode_off
);

   // register storage; index 0 internal, 1..3 external
   logic [7:0]  cfg_q,       cfg_d;
   logic [3:0]  rate_q,      rate_d;
   logic [7:0]  up_int_q    [NUM_CHAN];
   logic [7:0]  up_int_d    [NUM_CHAN];
   logic [7:0]  lo_int_q    [NUM_CHAN];
   logic [7:0]  lo_int_d    [NUM_CHAN];
   logic [2:0]  up_frac_q   [NUM_CHAN];
   logic [2:0]  up_frac_d   [NUM_CHAN];
   logic [2:0]  lo_frac_q   [NUM_CHAN];
   logic [2:0]  lo_frac_d   [NUM_CHAN];
   // limits in force for the running conversion
   logic [10:0] sh_up_q     [NUM_CHAN];
   logic [10:0] sh_up_d     [NUM_CHAN];
   logic [10:0] sh_lo_q     [NUM_CHAN];
   logic [10:0] sh_lo_d     [NUM_CHAN];
   // per-channel status
   logic [3:0]  hstat_q,     hstat_d;
   logic [3:0]  lstat_q,     lstat_d;
   logic [2:0]  fstat_q,     fstat_d;
   logic [3:0]  cmp_hi_q,    cmp_hi_d;
   logic        warn_q,      warn_d;
   logic        crit_q,      crit_d;
   logic [7:0]  rdata_q,     rdata_d;
   logic        rvalid_q,    rvalid_d;
   logic [31:0] tick_q,      tick_d;
   logic        req_q,       req_d;

   logic [10:0] temp        [NUM_CHAN];
   logic [3:0]  hi_hit;
   logic [3:0]  lo_hit;
   logic [7:0]  gstat;
   logic [3:0]  rate_eff;
   logic [31:0] period;

   assign temp[0] = {int_temp[10:3], 3'b000};
   assign temp[1] = ext1_temp;
   assign temp[2] = ext2_temp;
   assign temp[3] = ext3_temp;

   // unsigned compare serves both formats, offset binary keeps order
   for (genvar c = 0; c < NUM_CHAN; c++)
   begin : g_cmp
      assign hi_hit[c] = temp[c] > sh_up_q[c];
      assign lo_hit[c] = temp[c] <= sh_lo_q[c];
   end

   always_comb
   begin
      gstat           = 8'h00;
      gstat[ST_BUSY]  = conv_busy;
      gstat[ST_HIGH]  = |hstat_q;
      gstat[ST_LOW]   = |lstat_q;
      gstat[ST_FAULT] = |fstat_q;
      gstat[ST_THERM] = |therm_over;
   end

   // register writes; aliases land in the same storage
   always_comb
   begin
      cfg_d     = cfg_q;
      rate_d    = rate_q;
      up_int_d  = up_int_q;
      lo_int_d  = lo_int_q;
      up_frac_d = up_frac_q;
      lo_frac_d = lo_frac_q;
      if (reg_wr)
      begin
         case (reg_addr)
            A_CFG, A_CFG_ALIAS:   cfg_d = reg_wdata & CFG_WMASK;
            A_RATE, A_RATE_ALIAS: rate_d = reg_wdata[3:0];
            A_IUP, A_IUP_ALIAS:   up_int_d[0] = reg_wdata;
            A_ILO, A_ILO_ALIAS:   lo_int_d[0] = reg_wdata;
            A_E1UP, A_E1UP_ALIAS: up_int_d[1] = reg_wdata;
            A_E1LO, A_E1LO_ALIAS: lo_int_d[1] = reg_wdata;
            A_E1UP_F:             up_frac_d[1] = reg_wdata[7:5];
            A_E1LO_F:             lo_frac_d[1] = reg_wdata[7:5];
            A_E2UP:               up_int_d[2] = reg_wdata;
            A_E2LO:               lo_int_d[2] = reg_wdata;
            A_E2UP_F:             up_frac_d[2] = reg_wdata[7:5];
            A_E2LO_F:             lo_frac_d[2] = reg_wdata[7:5];
            A_E3UP:               up_int_d[3] = reg_wdata;
            A_E3LO:               lo_int_d[3] = reg_wdata;
            A_E3UP_F:             up_frac_d[3] = reg_wdata[7:5];
            A_E3LO_F:             lo_frac_d[3] = reg_wdata[7:5];
            default:              cfg_d = cfg_q;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg_q  <= CFG_RST;
         rate_q <= RATE_RST;
         for (int c = 0; c < NUM_CHAN; c++)
         begin
            up_int_q[c]  <= UP_RST;
            lo_int_q[c]  <= LO_RST;
            up_frac_q[c] <= FRAC_RST;
            lo_frac_q[c] <= FRAC_RST;
         end
      end
      else
      begin
         cfg_q     <= cfg_d;
         rate_q    <= rate_d;
         up_int_q  <= up_int_d;
         lo_int_q  <= lo_int_d;
         up_frac_q <= up_frac_d;
         lo_frac_q <= lo_frac_d;
      end
   end

   // limits are sampled when a conversion begins, so standby writes wait for it
   always_comb
   begin
      sh_up_d = sh_up_q;
      sh_lo_d = sh_lo_q;
      if (conv_start)
      begin
         for (int c = 0; c < NUM_CHAN; c++)
         begin
            sh_up_d[c] = {up_int_q[c], (c == 0) ? FRAC_RST : up_frac_q[c]};
            sh_lo_d[c] = {lo_int_q[c], (c == 0) ? FRAC_RST : lo_frac_q[c]};
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int c = 0; c < NUM_CHAN; c++)
         begin
            sh_up_q[c] <= {UP_RST, FRAC_RST};
            sh_lo_q[c] <= {LO_RST, FRAC_RST};
         end
      end
      else
      begin
         sh_up_q <= sh_up_d;
         sh_lo_q <= sh_lo_d;
      end
   end

   // sticky status: a new breach in the reading cycle survives the clear
   always_comb
   begin
      hstat_d  = hstat_q;
      lstat_d  = lstat_q;
      fstat_d  = fstat_q;
      cmp_hi_d = cmp_hi_q;
      if (reg_rd && reg_addr == A_HSTAT)
         hstat_d = 4'h0;
      if (reg_rd && reg_addr == A_LSTAT)
         lstat_d = 4'h0;
      if (reg_rd && reg_addr == A_FAULT)
         fstat_d = 3'h0;
      if (conv_done)
      begin
         hstat_d  = hstat_d | hi_hit;
         lstat_d  = lstat_d | lo_hit;
         fstat_d  = fstat_d | diode_fault;
         cmp_hi_d = hi_hit;
      end
   end

   // alert: busy and critical never reach it
   always_comb
   begin
      if (cfg_q[CFG_COMP])
         warn_d = |cmp_hi_q;
      else
         warn_d = (gstat[ST_HIGH] | gstat[ST_LOW] | gstat[ST_FAULT])
                  & ~cfg_q[CFG_MASK_ALL];
      crit_d = gstat[ST_THERM];
   end

   // register reads
   always_comb
   begin
      rvalid_d = reg_rd;
      rdata_d  = rdata_q;
      if (reg_rd)
      begin
         case (reg_addr)
            A_GSTAT:              rdata_d = gstat;
            A_CFG, A_CFG_ALIAS:   rdata_d = cfg_q;
            A_RATE, A_RATE_ALIAS: rdata_d = {4'h0, rate_q};
            A_IUP, A_IUP_ALIAS:   rdata_d = up_int_q[0];
            A_ILO, A_ILO_ALIAS:   rdata_d = lo_int_q[0];
            A_E1UP, A_E1UP_ALIAS: rdata_d = up_int_q[1];
            A_E1LO, A_E1LO_ALIAS: rdata_d = lo_int_q[1];
            A_E1UP_F:             rdata_d = {up_frac_q[1], 5'h00};
            A_E1LO_F:             rdata_d = {lo_frac_q[1], 5'h00};
            A_E2UP:               rdata_d = up_int_q[2];
            A_E2LO:               rdata_d = lo_int_q[2];
            A_E2UP_F:             rdata_d = {up_frac_q[2], 5'h00};
            A_E2LO_F:             rdata_d = {lo_frac_q[2], 5'h00};
            A_E3UP:               rdata_d = up_int_q[3];
            A_E3LO:               rdata_d = lo_int_q[3];
            A_E3UP_F:             rdata_d = {up_frac_q[3], 5'h00};
            A_E3LO_F:             rdata_d = {lo_frac_q[3], 5'h00};
            A_FAULT:              rdata_d = {4'h0, fstat_q, 1'b0};
            A_HSTAT:              rdata_d = {4'h0, hstat_q};
            A_LSTAT:              rdata_d = {4'h0, lstat_q};
            A_TSTAT:              rdata_d = {4'h0, therm_over};
            default:              rdata_d = 8'h00;
         endcase
      end
   end

   // conversion request timer; period doubles for each code step below the top
   always_comb
   begin
      rate_eff = (rate_q > RATE_MAX) ? RATE_FALLBACK : rate_q;
      period   = FAST_CYC << (RATE_MAX - rate_eff);
      req_d    = 1'b0;
      tick_d   = tick_q + 32'h0000_0001;
      if (tick_q >= period - 32'h0000_0001)
      begin
         tick_d = 32'h0000_0000;
         req_d  = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         hstat_q  <= 4'h0;
         lstat_q  <= 4'h0;
         fstat_q  <= 3'h0;
         cmp_hi_q <= 4'h0;
         warn_q   <= 1'b0;
         crit_q   <= 1'b0;
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
         tick_q   <= 32'h0000_0000;
         req_q    <= 1'b0;
      end
      else
      begin
         hstat_q  <= hstat_d;
         lstat_q  <= lstat_d;
         fstat_q  <= fstat_d;
         cmp_hi_q <= cmp_hi_d;
         warn_q   <= warn_d;
         crit_q   <= crit_d;
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
         tick_q   <= tick_d;
         req_q    <= req_d;
      end
   end

   assign reg_rdata                  = rdata_q;
   assign reg_rvalid                 = rvalid_q;
   assign warn_output                = warn_q;
   assign crit_output                = crit_q;
   assign conv_request               = req_q;
   assign rate_code                  = rate_eff;
   assign averaging_inhibit          = cfg_q[CFG_AVG];
   assign chan1_resistance_corr_off  = cfg_q[CFG_RC1];
   assign chan23_resistance_corr_off = cfg_q[CFG_RC23];
   assign ext_range                  = cfg_q[CFG_RANGE];
   assign paired_diode_off           = cfg_q[CFG_APD];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   busy_no_alert_a: assert property ((gstat[4:2] == 3'b000) && !cfg_q[CFG_COMP] |=> !warn_output)
      else $error("busy alone raised the alert");
   high_sets_a: assert property (conv_done && (|hi_hit) |=> gstat[ST_HIGH] ##1 gstat[ST_HIGH] || $past(reg_rd))
      else $error("high breach did not set high status");
   low_sets_a: assert property (conv_done && (|lo_hit) |=> gstat[ST_LOW])
      else $error("low breach did not set low status");
   fault_sets_a: assert property (conv_done && (|diode_fault) && !cfg_q[CFG_MASK_ALL] && !cfg_q[CFG_COMP]
                                  |=> ##1 warn_output)
      else $error("diode fault did not raise alert");
   crit_path_a: assert property ((|therm_over) [*2] |-> crit_output)
      else $error("critical flag did not reach critical output");
   read_clear_a: assert property (reg_rd && reg_addr == A_HSTAT && !conv_done |=> hstat_q == 4'h0)
      else $error("high status not cleared by read");
   mask_all_a: assert property ((cfg_q[CFG_MASK_ALL] && !cfg_q[CFG_COMP]) [*2] |-> !warn_output)
      else $error("alert asserted while masked");
   comp_mode_a: assert property (cfg_q[CFG_COMP] && (|cmp_hi_q) |=> warn_output)
      else $error("comparator mode ignored high breach");
   cfg_alias_a: assert property (reg_wr && reg_addr == A_CFG_ALIAS |=> cfg_q == ($past(reg_wdata) & CFG_WMASK))
      else $error("configuration alias write lost");
   rate_fallback_a: assert property (rate_q > RATE_MAX |-> rate_code == RATE_FALLBACK)
      else $error("unlisted rate code not mapped to one per second");
   high_alert_a: assert property (conv_done && (|hi_hit) && !cfg_q[CFG_MASK_ALL] && !cfg_q[CFG_COMP]
                                  |=> ##1 warn_output)
      else $error("high breach did not raise alert");
   low_alert_a: assert property (conv_done && (|lo_hit) && !cfg_q[CFG_MASK_ALL] && !cfg_q[CFG_COMP]
                                 |=> ##1 warn_output)
      else $error("low breach did not raise alert");
   // a result equal to the upper limit must stay quiet; a loose >= compare trips this
   equal_not_high_a: assert property (conv_done && temp[1] == sh_up_q[1]
                                      |=> !hstat_q[1] || $past(hstat_q[1]))
      else $error("equal result flagged as high");

   alert_cov_c:  cover property (conv_done && (|hi_hit) ##2 warn_output);
   clear_cov_c:  cover property (warn_output ##1 reg_rd && reg_addr == A_HSTAT ##[1:3] !warn_output);
   req_cov_c:    cover property (conv_request);
   mask_cov_c:   cover property (cfg_q[CFG_MASK_ALL] && gstat[ST_HIGH] && !warn_output);
   crit_cov_c:   cover property (crit_output && !warn_output);

endmodule : tms_monitor

// *** rtl/tms_pkg.sv ***
// Purpose: constants shared by the temperature monitor status and limit logic
// Assumes: 50 MHz clock, 8-bit register addresses and data
// Notes:   channel index 0 is internal, 1..3 are the external diodes
package tms_pkg;
   localparam int         NUM_CHAN       = 4;
   // register addresses
   localparam logic [7:0] A_GSTAT        = 8'h02;
   localparam logic [7:0] A_CFG          = 8'h03;
   localparam logic [7:0] A_CFG_ALIAS    = 8'h09;
   localparam logic [7:0] A_RATE         = 8'h04;
   localparam logic [7:0] A_RATE_ALIAS   = 8'h0A;
   localparam logic [7:0] A_IUP          = 8'h05;
   localparam logic [7:0] A_IUP_ALIAS    = 8'h0B;
   localparam logic [7:0] A_ILO          = 8'h06;
   localparam logic [7:0] A_ILO_ALIAS    = 8'h0C;
   localparam logic [7:0] A_E1UP         = 8'h07;
   localparam logic [7:0] A_E1UP_ALIAS   = 8'h0D;
   localparam logic [7:0] A_E1LO         = 8'h08;
   localparam logic [7:0] A_E1LO_ALIAS   = 8'h0E;
   localparam logic [7:0] A_E1UP_F       = 8'h13;
   localparam logic [7:0] A_E1LO_F       = 8'h14;
   localparam logic [7:0] A_E2UP         = 8'h15;
   localparam logic [7:0] A_E2LO         = 8'h16;
   localparam logic [7:0] A_E2UP_F       = 8'h17;
   localparam logic [7:0] A_E2LO_F       = 8'h18;
   localparam logic [7:0] A_FAULT        = 8'h1B;
   localparam logic [7:0] A_E3UP         = 8'h2C;
   localparam logic [7:0] A_E3LO         = 8'h2D;
   localparam logic [7:0] A_E3UP_F       = 8'h2E;
   localparam logic [7:0] A_E3LO_F       = 8'h2F;
   localparam logic [7:0] A_HSTAT        = 8'h35;
   localparam logic [7:0] A_LSTAT        = 8'h36;
   localparam logic [7:0] A_TSTAT        = 8'h37;
   // reset values
   localparam logic [7:0] CFG_RST        = 8'h80;
   localparam logic [3:0] RATE_RST       = 4'h6;
   localparam logic [7:0] UP_RST         = 8'h55;
   localparam logic [7:0] LO_RST         = 8'h00;
   localparam logic [2:0] FRAC_RST       = 3'h0;
   // configuration fields
   localparam int         CFG_MASK_ALL   = 7;
   localparam int         CFG_COMP       = 5;
   localparam int         CFG_RC1        = 4;
   localparam int         CFG_RC23       = 3;
   localparam int         CFG_RANGE      = 2;
   localparam int         CFG_AVG        = 1;
   localparam int         CFG_APD        = 0;
   localparam logic [7:0] CFG_WMASK      = 8'hBF;
   // general status fields
   localparam int         ST_BUSY        = 7;
   localparam int         ST_HIGH        = 4;
   localparam int         ST_LOW         = 3;
   localparam int         ST_FAULT       = 2;
   localparam int         ST_THERM       = 1;
   // rate codes
   localparam logic [3:0] RATE_MAX       = 4'hA;
   localparam logic [3:0] RATE_FALLBACK  = 4'h4;
   // timing: period at the fastest rate (64 per second)
   localparam int         CLK_PERIOD_NS  = 20;
   localparam int         FAST_PERIOD_NS = 15_625_000;
   localparam int         FAST_PERIOD_CYC = FAST_PERIOD_NS / CLK_PERIOD_NS;
endpackage : tms_pkg

// *** test/tb.sv ***
// Purpose: self-checking bench for the status, configuration, rate and limit registers
// Assumes: converter inputs are driven here in place of the measurement unit
// Notes:   fast timer shortened to 8 cycles so rate periods stay short
`timescale 1ns/100ps
module tb
   import tms_pkg::*;
;
   localparam int unsigned FAST = 8;
   logic        clk, rst_b, reg_wr, reg_rd, reg_rvalid, conv_busy, conv_start, conv_done;
   logic        warn_output, crit_output, conv_request, averaging_inhibit, ext_range, paired_diode_off;
   logic        chan1_resistance_corr_off, chan23_resistance_corr_off;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [10:0] int_temp, ext1_temp, ext2_temp, ext3_temp;
   logic [2:0]  diode_fault;
   logic [3:0]  therm_over, rate_code;
   int          miscompares, checks;

   tms_host_model tms_host_model_i (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
   tms_monitor #(.FAST_CYC(FAST)) tms_monitor_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .conv_busy(conv_busy), .conv_start(conv_start), .conv_done(conv_done),
      .int_temp(int_temp), .ext1_temp(ext1_temp), .ext2_temp(ext2_temp), .ext3_temp(ext3_temp),
      .diode_fault(diode_fault), .therm_over(therm_over), .warn_output(warn_output),
      .crit_output(crit_output), .conv_request(conv_request), .rate_code(rate_code),
      .averaging_inhibit(averaging_inhibit), .chan1_resistance_corr_off(chan1_resistance_corr_off),
      .chan23_resistance_corr_off(chan23_resistance_corr_off), .ext_range(ext_range),
      .paired_diode_off(paired_diode_off));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string msg);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : cmp8

   task automatic cmpb(input logic got, input logic exp, input string msg);
      cmp8({7'h00, got}, {7'h00, exp}, msg);
   endtask : cmpb

   task automatic cmpn(input int got, input int exp);
      checks++;
      if (got != exp)
      begin
         miscompares++;
         $display("CHECK FAILED %0t period got %0d exp %0d", $time, got, exp);
      end
   endtask : cmpn

   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      tms_host_model_i.rd(a, d, ok);
      cmpb(ok, 1'b1, "read answer");
      cmp8(d, e, $sformatf("reg %h", a));
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tms_host_model_i.wr(a, d);
   endtask : wr

   task automatic conv_begin;
      @(posedge clk);
      conv_start <= 1'b1;
      @(posedge clk);
      conv_start <= 1'b0;
   endtask : conv_begin

   // results are only valid with the done pulse, so they are scrambled afterwards
   task automatic conv_end(input logic [10:0] ti, input logic [10:0] e1, input logic [10:0] e2,
                           input logic [2:0] f);
      @(posedge clk);
      int_temp    <= ti;
      ext1_temp   <= e1;
      ext2_temp   <= e2;
      ext3_temp   <= 11'h100;
      diode_fault <= f;
      conv_done   <= 1'b1;
      @(posedge clk);
      conv_done   <= 1'b0;
      int_temp    <= ~ti;
      ext1_temp   <= ~e1;
      ext2_temp   <= ~e2;
      ext3_temp   <= ~11'h100;
      diode_fault <= ~f;
      @(posedge clk);
      #1;
   endtask : conv_end

   task automatic conv(input logic [10:0] ti, input logic [10:0] e1, input logic [10:0] e2,
                       input logic [2:0] f);
      conv_begin();
      conv_end(ti, e1, e2, f);
   endtask : conv

   task automatic wait_req(output int n);
      for (n = 1; n < 5000; n++)
      begin
         @(posedge clk);
         #1;
         if (conv_request === 1'b1)
            break;
      end
      if (n >= 5000)
      begin
         miscompares++;
         $display("CHECK FAILED %0t request timeout", $time);
         tally_and_finish();
      end
   endtask : wait_req

   task automatic s_reset;
      logic [7:0] ra [14] = '{8'h02, 8'h03, 8'h09, 8'h04, 8'h0A, 8'h05, 8'h0B, 8'h06, 8'h07, 8'h13,
                              8'h15, 8'h2C, 8'h2F, 8'h40};
      logic [7:0] rv [14] = '{8'h00, 8'h80, 8'h80, 8'h06, 8'h06, 8'h55, 8'h55, 8'h00, 8'h55, 8'h00,
                              8'h55, 8'h55, 8'h00, 8'h00};
      cmp8({4'h0, rate_code}, 8'h06, "rate out");
      cmpb(ext_range, 1'b0, "range out");
      cmpb(warn_output | crit_output | conv_request, 1'b0, "reset outs");
      for (int i = 0; i < 14; i++)
         chk(ra[i], rv[i]);
   endtask : s_reset

   task automatic s_cfg;
      wr(A_CFG_ALIAS, 8'h5F);
      chk(A_CFG, 8'h1F);
      cmpb(chan1_resistance_corr_off, 1'b1, "corr1");
      cmpb(chan23_resistance_corr_off, 1'b1, "corr23");
      cmpb(ext_range, 1'b1, "range");
      cmpb(averaging_inhibit, 1'b1, "avg");
      cmpb(paired_diode_off, 1'b1, "paired");
      wr(A_CFG, 8'h00);
      chk(A_CFG_ALIAS, 8'h00);
      cmpb(averaging_inhibit | chan1_resistance_corr_off | ext_range, 1'b0, "cfg off");
      cmpb(chan23_resistance_corr_off | paired_diode_off, 1'b0, "cfg off 2");
      wr(A_RATE_ALIAS, 8'hFA);
      chk(A_RATE, 8'h0A);
      cmp8({4'h0, rate_code}, 8'h0A, "rate A");
      wr(A_RATE, 8'h0F);
      chk(A_RATE_ALIAS, 8'h0F);
      cmp8({4'h0, rate_code}, 8'h04, "rate F");
      wr(A_IUP_ALIAS, 8'h3C);
      chk(A_IUP, 8'h3C);
      wr(A_IUP, 8'h55);
      wr(A_E2UP_F, 8'hFF);
      chk(A_E2UP_F, 8'hE0);
      wr(A_E2UP_F, 8'h00);
      wr(A_GSTAT, 8'hFF);
      chk(A_GSTAT, 8'h00);
   endtask : s_cfg

   task automatic s_busy;
      @(posedge clk);
      conv_busy <= 1'b1;
      chk(A_GSTAT, 8'h80);
      cmpb(warn_output | crit_output, 1'b0, "busy outputs");
      @(posedge clk);
      conv_busy <= 1'b0;
   endtask : s_busy

   task automatic s_high;
      wr(A_E1UP, 8'h50);
      wr(A_E1UP_F, 8'h20);
      conv_begin();
      wr(A_E1UP, 8'h00);
      conv_end(11'h100, 11'h281, 11'h100, 3'h0);
      chk(A_GSTAT, 8'h00);
      conv(11'h100, 11'h281, 11'h100, 3'h0);
      cmpb(warn_output, 1'b1, "high warn");
      chk(A_GSTAT, 8'h10);
      wr(A_CFG, 8'h80);
      chk(A_HSTAT, 8'h02);
      chk(A_GSTAT, 8'h00);
      conv(11'h100, 11'h281, 11'h100, 3'h0);
      chk(A_GSTAT, 8'h10);
      cmpb(warn_output, 1'b0, "masked");
      wr(A_CFG, 8'hA0);
      conv(11'h100, 11'h281, 11'h100, 3'h0);
      cmpb(warn_output, 1'b1, "comparator");
      wr(A_E1UP, 8'h55);
      conv(11'h100, 11'h281, 11'h100, 3'h0);
      cmpb(warn_output, 1'b0, "comparator off");
      wr(A_CFG, 8'h00);
      chk(A_HSTAT, 8'h02);
      chk(A_GSTAT, 8'h00);
   endtask : s_high

   task automatic s_low;
      // limits are written in the plain binary format that the range bit selects
      wr(A_ILO, 8'h20);
      wr(A_E2LO, 8'h20);
      conv(11'h107, 11'h100, 11'h100, 3'h0);
      cmpb(warn_output, 1'b1, "low warn");
      chk(A_GSTAT, 8'h08);
      chk(A_LSTAT, 8'h05);
      wr(A_ILO, 8'h00);
      wr(A_E2LO, 8'h00);
      conv(11'h107, 11'h100, 11'h100, 3'h0);
      chk(A_GSTAT, 8'h00);
      cmpb(warn_output, 1'b0, "low clear");
   endtask : s_low

   task automatic s_fault;
      conv(11'h100, 11'h100, 11'h100, 3'h5);
      cmpb(warn_output, 1'b1, "fault warn");
      chk(A_GSTAT, 8'h04);
      chk(A_FAULT, 8'h0A);
      chk(A_GSTAT, 8'h00);
      cmpb(warn_output, 1'b0, "fault clear");
   endtask : s_fault

   task automatic s_therm;
      @(posedge clk);
      therm_over <= 4'h4;
      repeat (2) @(posedge clk);
      #1;
      cmpb(crit_output, 1'b1, "crit");
      chk(A_GSTAT, 8'h02);
      chk(A_TSTAT, 8'h04);
      cmpb(warn_output, 1'b0, "crit no warn");
      @(posedge clk);
      therm_over <= 4'h0;
      repeat (2) @(posedge clk);
      #1;
      cmpb(crit_output, 1'b0, "crit off");
   endtask : s_therm

   task automatic s_rate;
      logic [3:0] codes [3] = '{4'hA, 4'h8, 4'hF};
      int         eff   [3] = '{10, 8, 4};
      int         n;
      for (int i = 0; i < 3; i++)
      begin
         wr(A_RATE, {4'h0, codes[i]});
         wait_req(n);
         wait_req(n);
         wait_req(n);
         cmpn(n, FAST << (10 - eff[i]));
      end
   endtask : s_rate

   initial
   begin
      miscompares = 0;
      checks      = 0;
      rst_b       = 1'b0;
      conv_busy   = 1'b0;
      conv_start  = 1'b0;
      conv_done   = 1'b0;
      int_temp    = 11'h100;
      ext1_temp   = 11'h100;
      ext2_temp   = 11'h100;
      ext3_temp   = 11'h100;
      diode_fault = 3'h0;
      therm_over  = 4'h0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      s_reset();
      s_cfg();
      s_busy();
      s_high();
      s_low();
      s_fault();
      s_therm();
      s_rate();
      tally_and_finish();
   end
endmodule : tb

// *** test/tms_host_model.sv ***
// Purpose: register-port host standing in for the SMBus engine
// Assumes: strobes are taken on the rising edge, read data stands one cycle later
// Notes:   idle address and data show the inverse of the last value, never a stale copy
`timescale 1ns/100ps
module tms_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid,
   output      logic [7:0] reg_addr,
   output      logic       reg_wr,
   output      logic       reg_rd,
   output      logic [7:0] reg_wdata
);
   initial
   begin
      reg_addr  = 8'hFF;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 8'hFF;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   // answer is registered on the taking edge, so it is looked at right after that edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1;
      ok = (reg_rvalid === 1'b1);
      d  = reg_rdata;
   endtask : rd
endmodule : tms_host_model
